// File: logic/prm_in_route.sv
module prm_in_route #(
    parameter logic [prm_pkg::NUM_PINS-1:0] VALID_MASK = 16'hFFFF
) (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst,
    prm_pin_if.route                       pins,
    input  wire logic [prm_pkg::SEL_W-1:0] i_sel,
    input  wire logic                      i_assigned,
    output logic                           o_connected,
    output logic                           o_level
);

    logic connect;

    // Pin reaches the input only when assigned, in range and not analog
    assign connect = i_assigned && VALID_MASK[i_sel] && !pins.analog[i_sel];

    // Registered peripheral input level, idle when disconnected
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_level     <= prm_pkg::LEVEL_IDLE;
            o_connected <= 1'b0;
        end else begin
            o_level     <= connect ? pins.level[i_sel] : prm_pkg::LEVEL_IDLE;
            o_connected <= connect;
        end
    end

endmodule

// File: logic/prm_pin_if.sv
interface prm_pin_if;
    logic [prm_pkg::NUM_PINS-1:0] level;
    logic [prm_pkg::NUM_PINS-1:0] analog;

    modport mux   (output level, output analog);
    modport route (input level, input analog);
endinterface

// File: logic/prm_pkg.sv
package prm_pkg;

    // Pin and field sizes
    localparam int NUM_PINS   = 16;
    localparam int SEL_W      = 4;
    localparam int NUM_IN     = 20;
    localparam int IDX_W      = 5;
    localparam int NUM_OUT_FN = 11;

    // Peripheral input indices
    localparam logic [IDX_W-1:0] IN_IRQ1      = 5'h00;
    localparam logic [IDX_W-1:0] IN_IRQ2      = 5'h01;
    localparam logic [IDX_W-1:0] IN_IRQ3      = 5'h02;
    localparam logic [IDX_W-1:0] IN_IRQ4      = 5'h03;
    localparam logic [IDX_W-1:0] IN_TMR2_CLK  = 5'h04;
    localparam logic [IDX_W-1:0] IN_TMR3_CLK  = 5'h05;
    localparam logic [IDX_W-1:0] IN_TMR4_CLK  = 5'h06;
    localparam logic [IDX_W-1:0] IN_TMR5_CLK  = 5'h07;
    localparam logic [IDX_W-1:0] IN_CAPT1     = 5'h08;
    localparam logic [IDX_W-1:0] IN_CAPT2     = 5'h09;
    localparam logic [IDX_W-1:0] IN_CAPT3     = 5'h0A;
    localparam logic [IDX_W-1:0] IN_CAPT4     = 5'h0B;
    localparam logic [IDX_W-1:0] IN_CAPT5     = 5'h0C;
    localparam logic [IDX_W-1:0] IN_CMP_FLT_A = 5'h0D;
    localparam logic [IDX_W-1:0] IN_CMP_FLT_B = 5'h0E;
    localparam logic [IDX_W-1:0] IN_UART1_RX  = 5'h0F;
    localparam logic [IDX_W-1:0] IN_UART1_CTS = 5'h10;
    localparam logic [IDX_W-1:0] IN_SPI1_DI   = 5'h11;
    localparam logic [IDX_W-1:0] IN_SPI1_CLK  = 5'h12;
    localparam logic [IDX_W-1:0] IN_SPI1_SS   = 5'h13;

    // Pins each input may be routed from (group A is pins 0-7, group B pins 8-15)
    localparam logic [NUM_PINS-1:0] GRP_A = 16'h00FF;
    localparam logic [NUM_PINS-1:0] GRP_B = 16'hFF00;
    localparam logic [NUM_PINS-1:0] IN_VALID_MASK [NUM_IN] = '{
        GRP_A, GRP_B, GRP_A, GRP_B, GRP_A, GRP_B, GRP_A, GRP_B,
        GRP_A, GRP_B, GRP_A, GRP_B, GRP_A, GRP_A, GRP_B, GRP_A,
        GRP_B, GRP_A, GRP_B, GRP_A
    };

    // Output function codes held per pin
    localparam logic [SEL_W-1:0] OUT_NONE      = 4'h0;
    localparam logic [SEL_W-1:0] OUT_UART1_TX  = 4'h1;
    localparam logic [SEL_W-1:0] OUT_UART1_RTS = 4'h2;
    localparam logic [SEL_W-1:0] OUT_SPI1_DO   = 4'h3;
    localparam logic [SEL_W-1:0] OUT_SPI1_CLK  = 4'h4;
    localparam logic [SEL_W-1:0] OUT_SPI1_SS   = 4'h5;
    localparam logic [SEL_W-1:0] OUT_CMP1      = 4'h6;
    localparam logic [SEL_W-1:0] OUT_CMP2      = 4'h7;
    localparam logic [SEL_W-1:0] OUT_CMP3      = 4'h8;
    localparam logic [SEL_W-1:0] OUT_CMP4      = 4'h9;
    localparam logic [SEL_W-1:0] OUT_CMP5      = 4'hA;

    // Values after reset
    localparam logic [SEL_W-1:0]  IN_SEL_RST  = 4'h0;
    localparam logic [SEL_W-1:0]  OUT_SEL_RST = 4'h0;
    localparam logic              LEVEL_IDLE  = 1'b0;

endpackage

// File: logic/prm_top.sv
module prm_top (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rst,
    // Configuration write port
    input  wire logic                           i_cfg_wr,
    input  wire logic                           i_cfg_is_out,
    input  wire logic [prm_pkg::IDX_W-1:0]      i_cfg_index,
    input  wire logic [prm_pkg::SEL_W-1:0]      i_cfg_value,
    input  wire logic                           i_cfg_unlock,
    output logic                                o_cfg_refused,
    // Remappable pins
    input  wire logic [prm_pkg::NUM_PINS-1:0]   i_pin_in,
    input  wire logic [prm_pkg::NUM_PINS-1:0]   i_pin_analog,
    output logic      [prm_pkg::NUM_PINS-1:0]   o_pin_out,
    output logic      [prm_pkg::NUM_PINS-1:0]   o_pin_oe,
    // Fixed default digital functions of each pin
    input  wire logic [prm_pkg::NUM_PINS-1:0]   i_dflt_out,
    input  wire logic [prm_pkg::NUM_PINS-1:0]   i_dflt_oe,
    output logic      [prm_pkg::NUM_PINS-1:0]   o_dflt_in,
    // Remappable peripheral outputs, indexed by function code
    input  wire logic [prm_pkg::NUM_OUT_FN-1:0] i_fn_out,
    input  wire logic [prm_pkg::NUM_OUT_FN-1:0] i_fn_active,
    // Remappable peripheral inputs, their status and per-pin output remap status
    output logic      [prm_pkg::NUM_IN-1:0]     o_periph_in,
    output logic      [prm_pkg::NUM_IN-1:0]     o_in_connected,
    output logic      [prm_pkg::NUM_PINS-1:0]   o_pin_remapped,
    output logic      [prm_pkg::NUM_PINS-1:0]   o_pin_overridden
);

    localparam int EXT_W = 1 << prm_pkg::SEL_W;

    logic [prm_pkg::SEL_W-1:0]    in_sel_reg  [prm_pkg::NUM_IN];
    logic [prm_pkg::NUM_IN-1:0]   in_assigned_reg;
    logic [prm_pkg::SEL_W-1:0]    out_sel_reg [prm_pkg::NUM_PINS];

    logic                         cfg_in_hit;
    logic                         cfg_out_hit;
    logic                         cfg_take;

    logic [EXT_W-1:0]             fn_out_ext;
    logic [EXT_W-1:0]             fn_active_ext;

    logic [prm_pkg::NUM_PINS-1:0] pin_out_next;
    logic [prm_pkg::NUM_PINS-1:0] pin_oe_next;
    logic [prm_pkg::NUM_PINS-1:0] dflt_in_next;
    logic [prm_pkg::NUM_PINS-1:0] remapped_next;
    logic [prm_pkg::NUM_PINS-1:0] overridden_next;

    prm_pin_if pin_bus ();

    // Write decode: index must name an existing select of the chosen set
    assign cfg_in_hit  = !i_cfg_is_out && (i_cfg_index < prm_pkg::NUM_IN);
    assign cfg_out_hit = i_cfg_is_out && (i_cfg_index < prm_pkg::NUM_PINS);
    assign cfg_take    = i_cfg_wr && i_cfg_unlock && (cfg_in_hit || cfg_out_hit);

    // Input select fields, one per peripheral input
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < prm_pkg::NUM_IN; i++) begin
                in_sel_reg[i] <= prm_pkg::IN_SEL_RST;
            end
        end else if (cfg_take && cfg_in_hit) begin
            in_sel_reg[i_cfg_index] <= i_cfg_value;
        end
    end

    // Assigned flags: no input is routed until first written
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            in_assigned_reg <= '0;
        end else if (cfg_take && cfg_in_hit) begin
            in_assigned_reg[i_cfg_index] <= 1'b1;
        end
    end

    // Output select fields, one per remappable pin
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int p = 0; p < prm_pkg::NUM_PINS; p++) begin
                out_sel_reg[p] <= prm_pkg::OUT_SEL_RST;
            end
        end else if (cfg_take && cfg_out_hit) begin
            out_sel_reg[i_cfg_index[prm_pkg::SEL_W-1:0]] <= i_cfg_value;
        end
    end

    // Refusal pulse for locked or unmapped writes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_refused <= 1'b0;
        end else begin
            o_cfg_refused <= i_cfg_wr && !cfg_take;
        end
    end

    // Function vectors widened to the full code space
    assign fn_out_ext    = {{(EXT_W - prm_pkg::NUM_OUT_FN){1'b0}}, i_fn_out};
    assign fn_active_ext = {{(EXT_W - prm_pkg::NUM_OUT_FN){1'b0}}, i_fn_active};

    // Per-pin output priority: analog, then remapped, then default
    always_comb begin
        pin_out_next    = '0;
        pin_oe_next     = '0;
        dflt_in_next    = '0;
        remapped_next   = '0;
        overridden_next = '0;
        for (int p = 0; p < prm_pkg::NUM_PINS; p++) begin
            if (i_pin_analog[p]) begin
                pin_out_next[p] = 1'b0;
                pin_oe_next[p]  = 1'b0;
            end else if ((out_sel_reg[p] != prm_pkg::OUT_NONE)
                         && fn_active_ext[out_sel_reg[p]]) begin
                pin_out_next[p]    = fn_out_ext[out_sel_reg[p]];
                pin_oe_next[p]     = 1'b1;
                remapped_next[p]   = 1'b1;
                overridden_next[p] = i_dflt_oe[p];
            end else begin
                pin_out_next[p] = i_dflt_out[p];
                pin_oe_next[p]  = i_dflt_oe[p];
                dflt_in_next[p] = i_pin_in[p];
            end
        end
    end

    // Registered pin drivers and status
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out        <= '0;
            o_pin_oe         <= '0;
            o_dflt_in        <= '0;
            o_pin_remapped   <= '0;
            o_pin_overridden <= '0;
        end else begin
            o_pin_out        <= pin_out_next;
            o_pin_oe         <= pin_oe_next;
            o_dflt_in        <= dflt_in_next;
            o_pin_remapped   <= remapped_next;
            o_pin_overridden <= overridden_next;
        end
    end

    // Pin levels shared with every input router
    assign pin_bus.level  = i_pin_in;
    assign pin_bus.analog = i_pin_analog;

    // One router per peripheral input
    for (genvar g = 0; g < prm_pkg::NUM_IN; g++) begin : g_in
        prm_in_route #(
            .VALID_MASK (prm_pkg::IN_VALID_MASK[g])
        ) u_route (
            .i_ref_clk   (i_ref_clk),
            .i_rst       (i_rst),
            .pins        (pin_bus),
            .i_sel       (in_sel_reg[g]),
            .i_assigned  (in_assigned_reg[g]),
            .o_connected (o_in_connected[g]),
            .o_level     (o_periph_in[g])
        );
    end

endmodule

// File: tb/prm_pin_model.sv
module prm_pin_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_roll,
    output logic      [15:0] o_pin_in,
    output logic      [15:0] o_pin_analog,
    output logic      [15:0] o_dflt_out,
    output logic      [15:0] o_dflt_oe,
    output logic      [10:0] o_fn_out,
    output logic      [10:0] o_fn_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins and peripherals settle to new levels on request, else hold
    initial begin
        {o_pin_in, o_pin_analog, o_dflt_out, o_dflt_oe, o_fn_out, o_fn_active} = '0;
        forever begin
            @(posedge i_ref_clk);
            if (i_roll) begin
                o_pin_in     <= 16'($urandom);
                o_pin_analog <= 16'($urandom & $urandom); // Sparse analog use
                o_dflt_out   <= 16'($urandom);
                o_dflt_oe    <= 16'($urandom);
                o_fn_out     <= 11'($urandom);
                o_fn_active  <= 11'($urandom | $urandom);
            end
        end
    end
endmodule

// File: tb/prm_top_sva.sv
module prm_top_sva (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_cfg_wr,
    input wire logic        i_cfg_is_out,
    input wire logic [4:0]  i_cfg_index,
    input wire logic        i_cfg_unlock,
    input wire logic        o_cfg_refused,
    input wire logic [15:0] i_pin_analog,
    input wire logic [15:0] o_pin_out,
    input wire logic [15:0] o_pin_oe,
    input wire logic [15:0] i_dflt_out,
    input wire logic [15:0] i_dflt_oe,
    input wire logic [15:0] o_dflt_in,
    input wire logic [19:0] o_periph_in,
    input wire logic [19:0] o_in_connected,
    input wire logic [15:0] o_pin_remapped,
    input wire logic [15:0] o_pin_overridden
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // Write attempts split by protection state and index range
    sequence s_locked_wr;
        i_cfg_wr && !i_cfg_unlock;
    endsequence
    sequence s_good_wr;
        i_cfg_wr && i_cfg_unlock && (i_cfg_is_out ? i_cfg_index < 5'h10 : i_cfg_index < 5'h14);
    endsequence
    a_locked_refused: assert property (s_locked_wr |=> o_cfg_refused)
        else $error("locked write not refused");
    a_good_taken: assert property (s_good_wr |=> !o_cfg_refused)
        else $error("valid write refused");
    a_refuse_cause: assert property (o_cfg_refused |-> $past(i_cfg_wr))
        else $error("refusal without write");
    a_analog_no_drive: assert property ((o_pin_oe & $past(i_pin_analog)) == 16'h0000)
        else $error("analog pin driven");
    a_analog_no_in: assert property ((o_dflt_in & $past(i_pin_analog)) == 16'h0000)
        else $error("analog pin passed to default input");
    a_remap_wins: assert property (((o_dflt_in | ~o_pin_oe) & o_pin_remapped) == 16'h0000)
        else $error("remapped pin not exclusive");
    a_override_flag: assert property
        ((o_pin_overridden & ~(o_pin_remapped & $past(i_dflt_oe))) == 16'h0000)
        else $error("override flag without cause");
    a_dflt_kept: assert property (!$past(i_rst) |->
        (((~o_pin_oe | (o_pin_out ^ $past(i_dflt_out))) & $past(i_dflt_oe)
        & ~$past(i_pin_analog) & ~o_pin_remapped) == 16'h0000))
        else $error("default function lost");
    a_idle_input: assert property ((o_periph_in & ~o_in_connected) == 20'h00000)
        else $error("disconnected input not idle");
endmodule

bind prm_top prm_top_sva prm_top_sva_i (.*);

// File: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk, i_rst, i_cfg_wr, i_cfg_is_out, i_cfg_unlock, o_cfg_refused, roll;
    logic [4:0]  i_cfg_index;
    logic [3:0]  i_cfg_value;
    logic [15:0] i_pin_in, i_pin_analog, i_dflt_out, i_dflt_oe, o_dflt_in, o_pin_out, o_pin_oe;
    logic [15:0] o_pin_remapped, o_pin_overridden;
    logic [10:0] i_fn_out, i_fn_active;
    logic [19:0] o_periph_in, o_in_connected;
    logic [3:0]  in_sel [20];
    logic [19:0] in_asg;
    logic [3:0]  out_code [16];
    int          err_count, num_checks, i;
    prm_top prm_top_i (
        .i_ref_clk        (i_ref_clk),
        .i_rst            (i_rst),
        .i_cfg_wr         (i_cfg_wr),
        .i_cfg_is_out     (i_cfg_is_out),
        .i_cfg_index      (i_cfg_index),
        .i_cfg_value      (i_cfg_value),
        .i_cfg_unlock     (i_cfg_unlock),
        .o_cfg_refused    (o_cfg_refused),
        .i_pin_in         (i_pin_in),
        .i_pin_analog     (i_pin_analog),
        .o_pin_out        (o_pin_out),
        .o_pin_oe         (o_pin_oe),
        .i_dflt_out       (i_dflt_out),
        .i_dflt_oe        (i_dflt_oe),
        .o_dflt_in        (o_dflt_in),
        .i_fn_out         (i_fn_out),
        .i_fn_active      (i_fn_active),
        .o_periph_in      (o_periph_in),
        .o_in_connected   (o_in_connected),
        .o_pin_remapped   (o_pin_remapped),
        .o_pin_overridden (o_pin_overridden)
    );
    prm_pin_model prm_pin_model_i (.i_ref_clk(i_ref_clk), .i_roll(roll), .o_pin_in(i_pin_in),
        .o_pin_analog(i_pin_analog), .o_dflt_out(i_dflt_out), .o_dflt_oe(i_dflt_oe),
        .o_fn_out(i_fn_out), .o_fn_active(i_fn_active));
    // Clock and watchdog
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #400000;
        err_count++;
        conclude();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        i_rst <= 1'b1;
        in_asg = '0;
        for (int k = 0; k < 20; k++) in_sel[k] = 4'h0;
        for (int k = 0; k < 16; k++) out_code[k] = 4'h0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
    endtask
    // One write, then the refusal pulse and the shadow copy
    task automatic cfg(input logic o, input logic [4:0] x, input logic [3:0] v, input logic u);
        logic ok;
        ok = u && (o ? x < 5'h10 : x < 5'h14);
        @(posedge i_ref_clk);
        {i_cfg_wr, i_cfg_is_out, i_cfg_index, i_cfg_value, i_cfg_unlock} <= {1'b1, o, x, v, u};
        @(posedge i_ref_clk);
        i_cfg_wr <= 1'b0;
        #1;
        chk(32'(o_cfg_refused), 32'(!ok));
        if (ok && o) out_code[x[3:0]] = v;
        if (ok && !o) in_sel[x] = v;
        if (ok && !o) in_asg[x] = 1'b1;
    endtask
    // Expected pin bits: remapped, overridden, enable, value, default input
    function automatic logic [4:0] exp_pin(input int p);
        logic [3:0] c;
        logic       a, r;
        c = out_code[p];
        a = i_pin_analog[p];
        r = !a && c != 4'h0 && c < 4'hB && i_fn_active[c];
        return {r, r && i_dflt_oe[p], !a && (r || i_dflt_oe[p]),
                !a && (r ? i_fn_out[c] : i_dflt_out[p]), !a && !r && i_pin_in[p]};
    endfunction
    // Expected peripheral input: connected flag and level
    function automatic logic [1:0] exp_in(input int k);
        logic [3:0] c;
        logic       n;
        c = in_sel[k];
        n = in_asg[k] && prm_pkg::IN_VALID_MASK[k][c] && !i_pin_analog[c];
        return {n, n && i_pin_in[c]};
    endfunction
    // New pin levels, settle, compare every routed output
    task automatic check_all();
        logic [15:0] e_out, e_oe, e_din, e_rem, e_ovr;
        logic [19:0] e_con, e_pin;
        @(posedge i_ref_clk);
        roll <= 1'b1;
        @(posedge i_ref_clk);
        roll <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        #1;
        for (int p = 0; p < 16; p++) begin
            {e_rem[p], e_ovr[p], e_oe[p], e_out[p], e_din[p]} = exp_pin(p);
        end
        for (int k = 0; k < 20; k++) begin
            {e_con[k], e_pin[k]} = exp_in(k);
        end
        chk(o_pin_remapped, e_rem);
        chk(o_pin_overridden, e_ovr);
        chk(o_pin_oe, e_oe);
        chk(o_pin_out, e_out);
        chk(o_dflt_in, e_din);
        chk(o_in_connected, e_con);
        chk(o_periph_in, e_pin);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Test sequence
    initial begin
        {i_rst, i_cfg_wr, i_cfg_is_out, i_cfg_index, i_cfg_value, i_cfg_unlock, roll} = '0;
        void'($urandom(94715));
        do_reset();
        check_all();
        $display("test reset done");
        cfg(1'b0, prm_pkg::IN_UART1_RX, 4'h3, 1'b0);
        cfg(1'b1, 5'h02, 4'h1, 1'b0);
        cfg(1'b0, 5'h14, 4'h1, 1'b1);
        cfg(1'b1, 5'h10, 4'h1, 1'b1);
        check_all();
        $display("test refusals done");
        for (i = 0; i < 20; i++) cfg(1'b0, 5'(i), 4'($urandom_range(15)), 1'b1);
        check_all();
        for (i = 0; i < 16; i++) cfg(1'b1, 5'(i), 4'(i), 1'b1);
        check_all();
        $display("test all codes done");
        for (i = 0; i < 150; i++) begin
            cfg(1'($urandom), 5'($urandom_range(21)), 4'($urandom), 1'($urandom_range(7) != 0));
            check_all();
        end
        $display("test random done");
        do_reset();
        check_all();
        $display("test second reset done");
        conclude();
    end
endmodule
